// >>> logic/actpl_pkg.sv
// Package for the audio clock tree and PLL control block.
// Assumes one 10 MHz system clock and a byte-wide register port.
package actpl_pkg;

    // Register offsets
    localparam logic [7:0] REG_CORE_SEL  = 8'h04;
    localparam logic [7:0] REG_PLL_PR    = 8'h05;
    localparam logic [7:0] REG_PLL_J     = 8'h06;
    localparam logic [7:0] REG_FRAC_HI   = 8'h07;
    localparam logic [7:0] REG_FRAC_LO   = 8'h08;
    localparam logic [7:0] REG_FIRST_DIV = 8'h0B;
    localparam logic [7:0] REG_SECOND_DIV = 8'h0C;
    localparam logic [7:0] REG_OSR_HI    = 8'h0D;
    localparam logic [7:0] REG_OSR_LO    = 8'h0E;
    localparam logic [7:0] REG_GP_SEL    = 8'h19;
    localparam logic [7:0] REG_GP_DIV    = 8'h1A;
    localparam logic [7:0] REG_IF_CTRL   = 8'h1B;
    localparam logic [7:0] REG_BCLK_SEL  = 8'h1D;
    localparam logic [7:0] REG_BCLK_DIV  = 8'h1E;
    localparam logic [7:0] REG_PWR_STAT  = 8'h25;

    // Field positions
    localparam int DIV_EN_BIT    = 7;
    localparam int PLL_EN_BIT    = 7;
    localparam int BCLK_DRV_BIT  = 3;
    localparam int STAT_LEFT_BIT = 7;
    localparam int STAT_RIGHT_BIT = 3;

    // Values after reset
    localparam logic [7:0] RST_PLL_PR = 8'h11;
    localparam logic [7:0] RST_PLL_J  = 8'h04;
    localparam logic [7:0] RST_DIV    = 8'h01;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // Core clock sources
    localparam logic [1:0] SRC_MCLK = 2'h0;
    localparam logic [1:0] SRC_BCLK = 2'h1;
    localparam logic [1:0] SRC_GPIN = 2'h2;
    localparam logic [1:0] SRC_PLL  = 2'h3;

    // Divider slots
    localparam int DIV_NUM   = 5;
    localparam int DIV_FIRST = 0;
    localparam int DIV_SECOND = 1;
    localparam int DIV_OSR   = 2;
    localparam int DIV_BCLK  = 3;
    localparam int DIV_GP    = 4;
    localparam int CNT_W     = 10;

    typedef struct packed {
        logic        en;
        logic [3:0]  pre_div;
        logic [4:0]  mult_r;
        logic [5:0]  mult_j;
        logic [13:0] frac;
    } actpl_pll_cfg_t;

endpackage : actpl_pkg

// >>> logic/actpl_top.sv
// Audio clock tree: source select, cascaded dividers, bit clock and
// general-purpose clock outputs, and PLL parameter registers.
// Assumes pin clocks slower than half of clk_i; the analog PLL loop is
// outside and its output returns on pll_clk_i.
// Operation
// [R1] Two-bit field picks core input clock
// [R2] Modulator equals core over first times second
// [R3] Ten-bit oversampling value split over two
// [R4] Divider enable bit seven; both gate power
// [R5] Software keeps dividers on during shutdown
// [R6] Power flags read at bits seven, three
// [R7] Disable second divider, then first divider
// [R8] Parents powered down after their children
// [R9] Drive bit clock pin, divide 1..128
// [R10] Bit clock source: processing or modulator
// [R11] General clock on general pin, 1..128
// [R12] Three-bit general clock source select
// [R13] Keep core, processing, modulator under limits
// [R14] Keep sample, divider sources under limits
// [R15] PLL enable bit; output R times J.D/P
// [R16] P, R and J field positions
// [R17] PLL parameter ranges and reset defaults
// [R18] Fraction: six upper, eight lower bits
// [R19] Fraction takes effect on lower write
// [R20] Zero fraction PLL input, output ranges
// [R21] Nonzero fraction PLL input range
// [R22] Prefer plain dividers over the PLL
// [R23] First, second divider values 1..128
// [R24] PLL up before dividers, down after
// [R25] Disabled divider held idle and cleared
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module actpl_top
(
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic [7:0]                addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    input  wire logic                      mclk_i,
    input  wire logic                      bclk_i,
    input  wire logic                      general_pin_one_i,
    input  wire logic                      pll_clk_i,
    input  wire logic                      left_pwr_i,
    input  wire logic                      right_pwr_i,
    output logic                           bclk_o,
    output logic                           bclk_oe_n_o,
    output logic                           general_pin_one_o,
    output logic                           general_pin_one_oe_n_o,
    output logic                           proc_tick_o,
    output logic                           mod_tick_o,
    output logic                           sample_tick_o,
    output logic                           chan_pwr_ok_o,
    output actpl_pkg::actpl_pll_cfg_t      pll_cfg_o
);

    // Register file
    logic [1:0]  core_sel_r,  core_sel_nxt;
    logic [7:0]  pll_pr_r,    pll_pr_nxt;
    logic [5:0]  pll_j_r,     pll_j_nxt;
    logic [5:0]  frac_hi_r,   frac_hi_nxt;
    logic [13:0] frac_r,      frac_nxt;
    logic [7:0]  first_r,     first_nxt;
    logic [7:0]  second_r,    second_nxt;
    logic [1:0]  osr_hi_r,    osr_hi_nxt;
    logic [7:0]  osr_lo_r,    osr_lo_nxt;
    logic [2:0]  gp_sel_r,    gp_sel_nxt;
    logic [6:0]  gp_div_r,    gp_div_nxt;
    logic [7:0]  if_ctrl_r,   if_ctrl_nxt;
    logic [1:0]  bclk_sel_r,  bclk_sel_nxt;
    logic [6:0]  bclk_div_r,  bclk_div_nxt;
    logic [7:0]  rdata_r,     rdata_nxt;

    // Divider value field: zero encodes the largest count
    function automatic logic [9:0] div7(input logic [6:0] v);
        div7 = (v == 7'h00) ? 10'h080 : {3'h0, v};
    endfunction : div7

    function automatic logic [4:0] wrap4(input logic [3:0] v);
        wrap4 = (v == 4'h0) ? 5'h10 : {1'b0, v};
    endfunction : wrap4

    always_comb
    begin
        core_sel_nxt = core_sel_r;
        pll_pr_nxt   = pll_pr_r;
        pll_j_nxt    = pll_j_r;
        frac_hi_nxt  = frac_hi_r;
        frac_nxt     = frac_r;
        first_nxt    = first_r;
        second_nxt   = second_r;
        osr_hi_nxt   = osr_hi_r;
        osr_lo_nxt   = osr_lo_r;
        gp_sel_nxt   = gp_sel_r;
        gp_div_nxt   = gp_div_r;
        if_ctrl_nxt  = if_ctrl_r;
        bclk_sel_nxt = bclk_sel_r;
        bclk_div_nxt = bclk_div_r;
        rdata_nxt    = 8'h00;
        if (wr_i)
        begin
            case (addr_i)
                actpl_pkg::REG_CORE_SEL:   core_sel_nxt = wdata_i[1:0];
                actpl_pkg::REG_PLL_PR:     pll_pr_nxt   = wdata_i;
                actpl_pkg::REG_PLL_J:      pll_j_nxt    = wdata_i[5:0];
                // [R19] Upper half staged only
                actpl_pkg::REG_FRAC_HI:    frac_hi_nxt  = wdata_i[5:0];
                // [R18] Fraction commits on lower write
                actpl_pkg::REG_FRAC_LO:    frac_nxt = {frac_hi_r, wdata_i};
                actpl_pkg::REG_FIRST_DIV:  first_nxt    = wdata_i;
                actpl_pkg::REG_SECOND_DIV: second_nxt   = wdata_i;
                actpl_pkg::REG_OSR_HI:     osr_hi_nxt   = wdata_i[1:0];
                actpl_pkg::REG_OSR_LO:     osr_lo_nxt   = wdata_i;
                actpl_pkg::REG_GP_SEL:     gp_sel_nxt   = wdata_i[2:0];
                actpl_pkg::REG_GP_DIV:     gp_div_nxt   = wdata_i[6:0];
                actpl_pkg::REG_IF_CTRL:    if_ctrl_nxt  = wdata_i;
                actpl_pkg::REG_BCLK_SEL:   bclk_sel_nxt = wdata_i[1:0];
                actpl_pkg::REG_BCLK_DIV:   bclk_div_nxt = wdata_i[6:0];
                default:                   ;
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                actpl_pkg::REG_CORE_SEL:   rdata_nxt = {6'h00, core_sel_r};
                actpl_pkg::REG_PLL_PR:     rdata_nxt = pll_pr_r;
                actpl_pkg::REG_PLL_J:      rdata_nxt = {2'h0, pll_j_r};
                actpl_pkg::REG_FRAC_HI:    rdata_nxt = {2'h0, frac_hi_r};
                actpl_pkg::REG_FRAC_LO:    rdata_nxt = frac_r[7:0];
                actpl_pkg::REG_FIRST_DIV:  rdata_nxt = first_r;
                actpl_pkg::REG_SECOND_DIV: rdata_nxt = second_r;
                actpl_pkg::REG_OSR_HI:     rdata_nxt = {6'h00, osr_hi_r};
                actpl_pkg::REG_OSR_LO:     rdata_nxt = osr_lo_r;
                actpl_pkg::REG_GP_SEL:     rdata_nxt = {5'h00, gp_sel_r};
                actpl_pkg::REG_GP_DIV:     rdata_nxt = {1'b0, gp_div_r};
                actpl_pkg::REG_IF_CTRL:    rdata_nxt = if_ctrl_r;
                actpl_pkg::REG_BCLK_SEL:   rdata_nxt = {6'h00, bclk_sel_r};
                actpl_pkg::REG_BCLK_DIV:   rdata_nxt = {1'b0, bclk_div_r};
                // [R6] Power status flags
                actpl_pkg::REG_PWR_STAT:
                    rdata_nxt = {left_pwr_i, 3'h0, right_pwr_i, 3'h0};
                default:                   rdata_nxt = 8'h00;
            endcase
        end
    end

    // [R17] PLL defaults after reset
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            core_sel_r <= actpl_pkg::SRC_MCLK;
            pll_pr_r   <= actpl_pkg::RST_PLL_PR;
            pll_j_r    <= actpl_pkg::RST_PLL_J[5:0];
            frac_hi_r  <= 6'h00;
            frac_r     <= 14'h0000;
            first_r    <= actpl_pkg::RST_DIV;
            second_r   <= actpl_pkg::RST_DIV;
            osr_hi_r   <= 2'h0;
            osr_lo_r   <= actpl_pkg::RST_ZERO;
            gp_sel_r   <= 3'h0;
            gp_div_r   <= actpl_pkg::RST_DIV[6:0];
            if_ctrl_r  <= actpl_pkg::RST_ZERO;
            bclk_sel_r <= 2'h0;
            bclk_div_r <= actpl_pkg::RST_DIV[6:0];
            rdata_r    <= 8'h00;
        end
        else
        begin
            core_sel_r <= core_sel_nxt;
            pll_pr_r   <= pll_pr_nxt;
            pll_j_r    <= pll_j_nxt;
            frac_hi_r  <= frac_hi_nxt;
            frac_r     <= frac_nxt;
            first_r    <= first_nxt;
            second_r   <= second_nxt;
            osr_hi_r   <= osr_hi_nxt;
            osr_lo_r   <= osr_lo_nxt;
            gp_sel_r   <= gp_sel_nxt;
            gp_div_r   <= gp_div_nxt;
            if_ctrl_r  <= if_ctrl_nxt;
            bclk_sel_r <= bclk_sel_nxt;
            bclk_div_r <= bclk_div_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Pin clocks: two flops, then rising-edge detect on the second
    // Index 0 mclk, 1 bclk, 2 general pin, 3 PLL output
    logic [3:0] pin_raw;
    logic [3:0] meta_r, meta_nxt;
    logic [3:0] sync_r, sync_nxt;
    logic [3:0] prev_r, prev_nxt;
    logic [3:0] edge_w;

    assign pin_raw = {pll_clk_i, general_pin_one_i, bclk_i, mclk_i};
    assign edge_w  = sync_r & ~prev_r;

    always_comb
    begin
        meta_nxt = pin_raw;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
            prev_r <= 4'h0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // [R1] Core input clock select
    logic core_tick;
    assign core_tick = edge_w[core_sel_r];

    // Divider chain
    logic [actpl_pkg::DIV_NUM-1:0] src_tick;
    logic [actpl_pkg::DIV_NUM-1:0] div_en;
    logic [actpl_pkg::DIV_NUM-1:0] div_tick;
    logic [actpl_pkg::DIV_NUM-1:0] div_lvl;
    logic [actpl_pkg::CNT_W-1:0]   div_val [actpl_pkg::DIV_NUM];
    logic [actpl_pkg::CNT_W-1:0]   div_cnt [actpl_pkg::DIV_NUM];
    logic first_en;
    logic second_en;
    logic bclk_drive;
    logic gp_src;

    assign first_en   = first_r[actpl_pkg::DIV_EN_BIT];
    assign second_en  = second_r[actpl_pkg::DIV_EN_BIT];
    assign bclk_drive = if_ctrl_r[actpl_pkg::BCLK_DRV_BIT];

    // [R2] First feeds second feeds oversampling
    assign src_tick[actpl_pkg::DIV_FIRST]  = core_tick;
    assign src_tick[actpl_pkg::DIV_SECOND] = div_tick[actpl_pkg::DIV_FIRST];
    assign src_tick[actpl_pkg::DIV_OSR]    = div_tick[actpl_pkg::DIV_SECOND];
    // [R10] Processing or modulator clock
    assign src_tick[actpl_pkg::DIV_BCLK] = bclk_sel_r[0]
        ? div_tick[actpl_pkg::DIV_SECOND] : div_tick[actpl_pkg::DIV_FIRST];
    assign src_tick[actpl_pkg::DIV_GP]   = gp_src;

    // [R12] General clock source select
    always_comb
    begin
        case (gp_sel_r)
            3'h0:    gp_src = edge_w[0];
            3'h1:    gp_src = edge_w[1];
            3'h2:    gp_src = core_tick;
            3'h3:    gp_src = edge_w[3];
            3'h4:    gp_src = div_tick[actpl_pkg::DIV_FIRST];
            3'h5:    gp_src = div_tick[actpl_pkg::DIV_SECOND];
            default: gp_src = core_tick;
        endcase
    end

    // [R4] Enable bits gate the dividers
    assign div_en[actpl_pkg::DIV_FIRST]  = first_en;
    assign div_en[actpl_pkg::DIV_SECOND] = first_en & second_en;
    assign div_en[actpl_pkg::DIV_OSR]    = first_en & second_en;
    // [R9] Bit clock only when driving
    assign div_en[actpl_pkg::DIV_BCLK]   = bclk_drive;
    assign div_en[actpl_pkg::DIV_GP]     = 1'b1;

    // [R23] First and second values 1..128
    assign div_val[actpl_pkg::DIV_FIRST]  = div7(first_r[6:0]);
    assign div_val[actpl_pkg::DIV_SECOND] = div7(second_r[6:0]);
    // [R3] Ten-bit oversampling value; zero means 1024
    assign div_val[actpl_pkg::DIV_OSR]    = {osr_hi_r, osr_lo_r};
    // [R9] [R11] Bit clock and general clock divide 1..128
    assign div_val[actpl_pkg::DIV_BCLK]   = div7(bclk_div_r);
    assign div_val[actpl_pkg::DIV_GP]     = div7(gp_div_r);

    genvar gi;
    generate
        for (gi = 0; gi < actpl_pkg::DIV_NUM; gi++)
        begin : g_div
            logic [actpl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
            logic [actpl_pkg::CNT_W-1:0] last_w;
            logic                        half_w;

            assign last_w = div_val[gi] - 10'h001;
            // A lowered divide value ends the running period on the next source tick
            // instead of letting the counter run round all 1024 counts
            assign div_tick[gi] = div_en[gi] & src_tick[gi]
                                  & (cnt_r >= last_w);
            assign div_cnt[gi]  = cnt_r;
            // High for the first half of each output period
            assign half_w = (cnt_r < {1'b0, div_val[gi][9:1]})
                            | (div_val[gi] == 10'h001);
            assign div_lvl[gi] = div_en[gi] & half_w;

            // [R25] Disabled divider held cleared
            always_comb
            begin
                cnt_nxt = cnt_r;
                if (!div_en[gi])
                    cnt_nxt = '0;
                else if (div_tick[gi])
                    cnt_nxt = '0;
                else if (src_tick[gi])
                    cnt_nxt = cnt_r + 10'h001;
            end

            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                    cnt_r <= '0;
                else
                    cnt_r <= cnt_nxt;
            end
        end
    endgenerate

    // Outputs, all registered
    logic        bclk_nxt, bclk_oe_n_nxt, gp_nxt, gp_oe_n_nxt;
    logic        proc_nxt, mod_nxt, fs_nxt, pwr_ok_nxt;
    actpl_pkg::actpl_pll_cfg_t pll_nxt;

    always_comb
    begin
        bclk_nxt      = div_lvl[actpl_pkg::DIV_BCLK];
        // [R9] Pin enable is low while driving
        bclk_oe_n_nxt = ~bclk_drive;
        gp_nxt        = div_lvl[actpl_pkg::DIV_GP];
        // Pin stays an input while it feeds the core clock
        gp_oe_n_nxt   = (core_sel_r == actpl_pkg::SRC_GPIN);
        proc_nxt      = div_tick[actpl_pkg::DIV_FIRST];
        mod_nxt       = div_tick[actpl_pkg::DIV_SECOND];
        fs_nxt        = div_tick[actpl_pkg::DIV_OSR];
        // [R4] Channel may power up only with both on
        pwr_ok_nxt    = first_en & second_en;
        // [R15] PLL enable and parameters
        // [R16] P and R fields, J field
        pll_nxt.en      = pll_pr_nxt[actpl_pkg::PLL_EN_BIT];
        pll_nxt.pre_div = (pll_pr_nxt[6:4] == 3'h0) ? 4'h8
                          : {1'b0, pll_pr_nxt[6:4]};
        pll_nxt.mult_r  = wrap4(pll_pr_nxt[3:0]);
        pll_nxt.mult_j  = pll_j_nxt;
        pll_nxt.frac    = frac_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            bclk_o                 <= 1'b0;
            bclk_oe_n_o            <= 1'b1;
            general_pin_one_o      <= 1'b0;
            general_pin_one_oe_n_o <= 1'b1;
            proc_tick_o            <= 1'b0;
            mod_tick_o             <= 1'b0;
            sample_tick_o          <= 1'b0;
            chan_pwr_ok_o          <= 1'b0;
            pll_cfg_o              <= '{1'b0, 4'h1, 5'h01, 6'h04, 14'h0};
        end
        else
        begin
            bclk_o                 <= bclk_nxt;
            bclk_oe_n_o            <= bclk_oe_n_nxt;
            general_pin_one_o      <= gp_nxt;
            general_pin_one_oe_n_o <= gp_oe_n_nxt;
            proc_tick_o            <= proc_nxt;
            mod_tick_o             <= mod_nxt;
            sample_tick_o          <= fs_nxt;
            chan_pwr_ok_o          <= pwr_ok_nxt;
            pll_cfg_o              <= pll_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // Checks
    core_sel_a: // [R1]
    assert property (@(posedge clk_i) disable iff (reset_i)
        edge_w[core_sel_r] && first_en && first_r[6:0] == 7'h01
        |=> proc_tick_o)
        else $error("selected source did not reach processing tick");

    frac_hold_a: // [R19]
    assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == actpl_pkg::REG_FRAC_HI) |=> $stable(frac_r))
        else $error("fraction changed on upper write");

    frac_commit_a: // [R18]
    assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == actpl_pkg::REG_FRAC_LO)
        |=> pll_cfg_o.frac == {$past(frac_hi_r), $past(wdata_i)})
        else $error("fraction not committed");

    mod_cascade_a: // [R2]
    assert property (@(posedge clk_i) disable iff (reset_i)
        div_tick[1] |-> div_tick[0] ##1 mod_tick_o && proc_tick_o)
        else $error("modulator tick without processing tick");

    div_idle_a: // [R25]
    assert property (@(posedge clk_i) disable iff (reset_i)
        !first_en ##1 !first_en |-> div_cnt[0] == 10'h000 && !proc_tick_o)
        else $error("disabled divider not idle");

    bclk_oe_a: // [R9]
    assert property (@(posedge clk_i) disable iff (reset_i)
        !bclk_drive |=> bclk_oe_n_o && !bclk_o)
        else $error("bit clock driven while disabled");

    pwr_stat_a: // [R6]
    assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_i && addr_i == actpl_pkg::REG_PWR_STAT)
        |=> rdata_o == {$past(left_pwr_i), 3'h0, $past(right_pwr_i), 3'h0})
        else $error("power status read wrong");

    pll_en_a: // [R15]
    assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == actpl_pkg::REG_PLL_PR)
        |=> pll_cfg_o.en == $past(wdata_i[7]))
        else $error("PLL enable not applied");

    chan_ok_a: // [R4]
    assert property (@(posedge clk_i) disable iff (reset_i)
        !(first_en && second_en) |=> !chan_pwr_ok_o)
        else $error("channel allowed with divider off");

endmodule : actpl_top

// >>> bench/actpl_top_test.sv
// Self-checking bench for the audio clock tree and PLL control block.
// Drives register port, pin clocks and power flags itself; no partner.
`timescale 1ns/10ps
module actpl_top_test;
    logic                      clk_i       = 1'b0;
    logic                      reset_i     = 1'b1;
    logic [7:0]                addr_i      = 8'h00;
    logic [7:0]                wdata_i     = 8'h00;
    logic                      wr_i        = 1'b0;
    logic                      rd_i        = 1'b0;
    logic [3:0]                pins        = 4'h0;
    logic                      left_pwr_i  = 1'b0;
    logic                      right_pwr_i = 1'b0;
    logic [7:0]                rdata_o;
    logic                      bclk_o, bclk_oe_n_o, gp_o, gp_oe_n_o;
    logic                      proc_tick_o, mod_tick_o, sample_tick_o;
    logic                      chan_pwr_ok_o;
    actpl_pkg::actpl_pll_cfg_t pll_cfg_o;
    logic [7:0]                exp_q[$];
    logic                      rd_seen = 1'b0;
    logic                      b_d = 1'b0;
    logic                      g_d = 1'b0;
    logic [31:0]               rnd = 32'hBCBD;
    logic [1:0]                sel = 2'h0;
    int                        ph = 0;
    int                        error_cnt = 0;
    int                        tests_run = 0;
    int                        n_p, n_m, n_s, n_b, n_g;
    logic [7:0] ra[13] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B,
        8'h0C, 8'h0D, 8'h0E, 8'h19, 8'h1A, 8'h1E, 8'h20};
    logic [7:0] rv[13] = '{8'h00, 8'h11, 8'h04, 8'h00, 8'h00, 8'h01,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};

    actpl_top actpl_top_i (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .mclk_i(pins[0]), .bclk_i(pins[1]),
        .general_pin_one_i(pins[2]), .pll_clk_i(pins[3]),
        .left_pwr_i(left_pwr_i), .right_pwr_i(right_pwr_i),
        .bclk_o(bclk_o), .bclk_oe_n_o(bclk_oe_n_o),
        .general_pin_one_o(gp_o), .general_pin_one_oe_n_o(gp_oe_n_o),
        .proc_tick_o(proc_tick_o), .mod_tick_o(mod_tick_o),
        .sample_tick_o(sample_tick_o), .chan_pwr_ok_o(chan_pwr_ok_o),
        .pll_cfg_o(pll_cfg_o));

    always #50 clk_i = ~clk_i;

    // Only the selected pin toggles, period 8 cycles, so a tick count
    // proves which source the core clock follows
    always @(posedge clk_i)
    begin
        ph   <= (ph + 1) % 8;
        pins <= (ph < 4) ? (4'h1 << sel) : 4'h0;
        rd_seen <= rd_i;
    end

    always @(negedge clk_i)
    begin
        n_p += (proc_tick_o === 1'b1);
        n_m += (mod_tick_o === 1'b1);
        n_s += (sample_tick_o === 1'b1);
        n_b += (bclk_o === 1'b1 && b_d === 1'b0);
        n_g += (gp_o === 1'b1 && g_d === 1'b0);
        b_d = bclk_o;
        g_d = gp_o;
        if (rd_seen)
            check(32'(rdata_o), 32'(exp_q.pop_front()));
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic near(input int a, input int b);
        return (a >= b - 1) && (a <= b + 1);
    endfunction : near

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask : rd

    task automatic win(input int n);
        n_p = 0;
        n_m = 0;
        n_s = 0;
        n_b = 0;
        n_g = 0;
        repeat (n) @(posedge clk_i);
        // Outputs are looked at away from the edge that launches them
        @(negedge clk_i);
    endtask : win

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        repeat (10000) @(posedge clk_i);
        error_cnt++;
        results();
    end

    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        @(negedge clk_i);
        check(32'({chan_pwr_ok_o, gp_oe_n_o}), 32'h0);
        check(32'(bclk_oe_n_o), 32'h1);
        $display("reset values done");
        // PLL input range kept by its source
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(8'h05, rnd[7:0]);
            wr(8'h06, {2'h0, rnd[13:9], 1'b1});
            rd(8'h05, rnd[7:0]);
            @(negedge clk_i);
            check(32'(pll_cfg_o.pre_div), rnd[6:4] ? rnd[6:4] : 8);
            check(32'(pll_cfg_o.mult_r), rnd[3:0] ? rnd[3:0] : 16);
            check(32'(pll_cfg_o.mult_j), 32'({rnd[13:9], 1'b1}));
            check(32'(pll_cfg_o.en), 32'(rnd[7]));
        end
        wr(8'h05, 8'h80);
        @(negedge clk_i);
        check(32'({pll_cfg_o.en, pll_cfg_o.pre_div, pll_cfg_o.mult_r}),
              32'({1'h1, 4'h8, 5'h10}));
        wr(8'h07, 8'h27);
        @(negedge clk_i);
        check(32'(pll_cfg_o.frac), 32'h0);
        wr(8'h08, 8'h0F);
        @(negedge clk_i);
        check(32'(pll_cfg_o.frac), 32'h270F);
        rd(8'h07, 8'h27);
        $display("pll settings done");
        wr(8'h25, 8'hFF);
        repeat (3)
        begin
            rnd = lfsr(rnd);
            left_pwr_i  <= rnd[0];
            right_pwr_i <= rnd[1];
            rd(8'h25, {rnd[0], 3'h0, rnd[1], 3'h0});
        end
        $display("power flags done");
        wr(8'h0B, 8'h81);
        wr(8'h0C, 8'h81);
        for (int s = 0; s < 4; s++)
        begin
            sel <= 2'(s);
            wr(8'h04, 8'(s));
            win(80);
            check(32'(near(n_p, 10)), 32'h1);
            check(32'(gp_oe_n_o), 32'(s == 2));
            sel <= 2'(s + 1);
            win(80);
            check(32'(near(n_p, 0)), 32'h1);
        end
        $display("source select done");
        sel <= 2'h0;
        wr(8'h04, 8'h00);
        // Slow pins keep clocks in limits
        wr(8'h0B, 8'h82);
        wr(8'h0C, 8'h83);
        wr(8'h0D, 8'h00);
        wr(8'h0E, 8'h02);
        wr(8'h1B, 8'h08);
        wr(8'h1D, 8'h00);
        wr(8'h1E, 8'h02);
        wr(8'h19, 8'h04);
        wr(8'h1A, 8'h03);
        win(960);
        check(32'({near(n_p, 60), near(n_m, 20), near(n_s, 10)}), 32'h7);
        check(32'({near(n_b, 30), near(n_g, 20)}), 32'h3);
        check(32'({chan_pwr_ok_o, bclk_oe_n_o}), 32'h2);
        wr(8'h1D, 8'h01);
        wr(8'h19, 8'h05);
        win(480);
        check(32'({near(n_b, 5), near(n_g, 3)}), 32'h3);
        $display("divider chain done");
        wr(8'h1B, 8'h00);
        wr(8'h19, 8'h02);
        left_pwr_i  <= 1'b0;
        right_pwr_i <= 1'b0;
        rd(8'h25, 8'h00);
        wr(8'h0C, 8'h03);
        win(160);
        check(32'({near(n_p, 10), near(n_m, 0)}), 32'h3);
        check(32'(chan_pwr_ok_o), 32'h0);
        wr(8'h0B, 8'h02);
        win(160);
        check(32'({near(n_p, 0), bclk_oe_n_o}), 32'h3);
        $display("divider disable done");
        results();
    end
endmodule : actpl_top_test
